// file: scl_pkg.sv
/*
  Shared constants and carrier types for the serial transceiver lane
  model: word widths, lock modes, detection timing and status bundles.
  Assumes a single 10 MHz clock domain and a synchronous reset.
*/
package scl_pkg;

  // ==========================================================================
  // Data path geometry
  // ==========================================================================
  localparam int unsigned SCL_MAX_W = 20;
  localparam int unsigned SCL_CNT_W = 5;
  localparam logic [1:0] SCL_WSEL_8 = 2'h0;
  localparam logic [1:0] SCL_WSEL_10 = 2'h1;
  localparam logic [1:0] SCL_WSEL_16 = 2'h2;
  localparam logic [1:0] SCL_WSEL_20 = 2'h3;
  localparam logic [SCL_CNT_W-1:0] SCL_CNT_ZERO = 5'h00;
  localparam logic [SCL_CNT_W-1:0] SCL_CNT_ONE = 5'h01;
  localparam logic [SCL_MAX_W-1:0] SCL_WORD_ZERO = 20'h0_0000;

  // ==========================================================================
  // Clock data recovery lock modes
  // ==========================================================================
  typedef enum logic [2:0] {
    SCL_LOCK_REF = 3'b001,
    SCL_LOCK_DATA = 3'b010,
    SCL_LOCK_OFF = 3'b100
  } scl_lock_t;

  // ==========================================================================
  // Receiver detection timing
  // ==========================================================================
  localparam int unsigned SCL_CLK_HZ = 10_000_000;
  localparam int unsigned SCL_DET_PULSE_NS = 1000;
  localparam int unsigned SCL_DET_WAIT_NS = 2000;
  localparam int unsigned SCL_DET_PULSE_CYC =
      (SCL_DET_PULSE_NS * (SCL_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SCL_DET_WAIT_CYC =
      SCL_DET_WAIT_NS * (SCL_CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned SCL_DET_CNT_W = 8;

  // ==========================================================================
  // Equalizer and multiplier encodings
  // ==========================================================================
  localparam int unsigned SCL_EQ_W = 4;
  localparam logic [SCL_EQ_W-1:0] SCL_EQ_RESET = 4'h0;
  localparam logic [2:0] SCL_MULT_RESET = 3'h0;
  localparam logic [4:0] SCL_PPM_RESET = 5'h00;

  // ==========================================================================
  // Status bundle
  // ==========================================================================
  typedef struct packed {
    logic pll_locked;
    logic data_locked;
    logic rx_present;
    logic detect_done;
  } scl_status_t;

endpackage

// file: scl_fifo.sv
/*
  Synchronous valid/ready FIFO with parameter width and depth.
  Assumes both sides share clk_i; depth is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module scl_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: scl_lane.sv
/*
  One transceiver lane: transmit serializer with electrical idle and
  receiver detection, clock data recovery lock control, and receive
  deserializer feeding a FIFO toward the fabric.
  Assumes serial pins and analog status arrive asynchronously; one clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Transmit words of 8, 10, 16 or 20 bits go out serially, LSB first.
// - Received bits are gathered into words of the chosen width, first bit LSB.
// - No symbol boundary search is done, so word framing is arbitrary.
// - In PCIe PHY mode a receiver is detected by a pulse and its reflection.
// - Force electrical idle idles the output in PCIe mode, in any power state.
// - An unused receive channel has its PLL and recovery unit powered down.
// - Lock-to-data wins, lock-to-reference alone forces reference, else auto.
// - With both override inputs unconnected the recovery unit runs automatic.
// - Auto mode moves to data lock only when the PLL is within the PPM limit.
// - The data-lock output shows when the recovery unit is locked to data.
// - The PLL lock output shows when the receiver PLL tracks its reference.
// - The PLL multiplier is chosen from 1, 4, 5, 8, 10, 16, 20 and 25.
// - Pre-emphasis is static or set at run time by the reconfig controller.
// - The adaptive equalizer may be powered down once it has settled.
// - The equalizer gain offers sixteen settings.
module scl_lane
  import scl_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter logic [3:0] PREEMPH_STATIC = 4'h0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration
  input wire logic [1:0] width_sel_i,
  input wire logic pcie_mode_i,
  input wire logic rx_used_i,
  input wire logic [2:0] mult_sel_i,
  input wire logic [4:0] ppm_limit_i,
  input wire logic [3:0] eq_gain_i,
  input wire logic eq_adapt_pd_i,
  input wire logic preemph_dyn_en_i,
  input wire logic [3:0] preemph_dyn_i,
  // Lock control overrides, tie low when unused
  input wire logic lock_to_ref_i,
  input wire logic lock_to_data_i,
  // Analog status inputs
  input wire logic pll_lock_raw_i,
  input wire logic [4:0] ppm_offset_i,
  input wire logic eq_settled_i,
  // Transmit fabric side
  input wire logic [SCL_MAX_W-1:0] tx_word_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic force_idle_i,
  input wire logic detect_req_i,
  // Transmit line side
  output logic tx_bit_o,
  output logic tx_idle_o,
  output logic tx_det_pulse_o,
  input wire logic tx_reflect_i,
  // Receive line side
  input wire logic rx_bit_i,
  // Receive fabric side
  output logic [SCL_MAX_W-1:0] rx_word_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // Status and analog controls
  output logic [3:0] status_o,
  output logic [2:0] lock_mode_o,
  output logic rx_pd_o,
  output logic eq_pd_o,
  output logic [3:0] eq_gain_o,
  output logic [4:0] mult_o,
  output logic [3:0] preemph_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [SCL_CNT_W-1:0] word_len(input logic [1:0] s);
    case (s)
      SCL_WSEL_8: word_len = 5'd8;
      SCL_WSEL_10: word_len = 5'd10;
      SCL_WSEL_16: word_len = 5'd16;
      default: word_len = 5'd20;
    endcase
  endfunction

  function automatic logic [4:0] mult_val(input logic [2:0] s);
    case (s)
      3'h0: mult_val = 5'd1;
      3'h1: mult_val = 5'd4;
      3'h2: mult_val = 5'd5;
      3'h3: mult_val = 5'd8;
      3'h4: mult_val = 5'd10;
      3'h5: mult_val = 5'd16;
      3'h6: mult_val = 5'd20;
      default: mult_val = 5'd25;
    endcase
  endfunction

  typedef enum logic [2:0] {
    DET_IDLE = 3'b001,
    DET_PULSE = 3'b010,
    DET_WAIT = 3'b100
  } scl_det_t;

  typedef struct packed {
    logic [1:0] sync_lock;
    logic [1:0] sync_rx;
    logic [1:0] sync_refl;
    logic [1:0] sync_settle;
    logic [SCL_MAX_W-1:0] tx_shift;
    logic [SCL_CNT_W-1:0] tx_cnt;
    logic tx_bit;
    logic tx_idle;
    logic tx_pulse;
    logic [SCL_MAX_W-1:0] rx_shift;
    logic [SCL_CNT_W-1:0] rx_cnt;
    logic [SCL_MAX_W-1:0] rx_word;
    logic rx_word_vld;
    scl_det_t det;
    logic [SCL_DET_CNT_W-1:0] det_cnt;
    logic seen;
    scl_status_t status;
    scl_lock_t lock;
    logic rx_pd;
    logic eq_pd;
    logic [3:0] eq_gain;
    logic [4:0] mult;
    logic [3:0] preemph;
  } scl_state_t;

  scl_state_t st;
  scl_state_t next_st;
  logic [SCL_MAX_W-1:0] fifo_data;
  logic fifo_valid;
  logic [SCL_CNT_W-1:0] wlen;
  logic ppm_ok;

  assign wlen = word_len(width_sel_i);
  assign ppm_ok = ppm_offset_i <= ppm_limit_i;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_st = st;
    next_st.sync_lock = {st.sync_lock[0], pll_lock_raw_i};
    next_st.sync_rx = {st.sync_rx[0], rx_bit_i};
    next_st.sync_refl = {st.sync_refl[0], tx_reflect_i};
    next_st.sync_settle = {st.sync_settle[0], eq_settled_i};
    next_st.tx_pulse = 1'b0;

    // Idle only counts in PCIe mode; the power state plays no part.
    next_st.tx_idle = pcie_mode_i && force_idle_i;

    // A new word loads when the last bit of the previous one leaves.
    if (st.tx_cnt == SCL_CNT_ZERO || st.tx_cnt == SCL_CNT_ONE) begin
      // Ready gates the take, so the cycle after reset takes no word.
      if (tx_valid_i && tx_ready_o) begin
        next_st.tx_bit = tx_word_i[0];
        next_st.tx_shift = tx_word_i >> 1;
        next_st.tx_cnt = wlen;
      end else begin
        next_st.tx_bit = 1'b0;
        next_st.tx_cnt = SCL_CNT_ZERO;
      end
    end else begin
      next_st.tx_bit = st.tx_shift[0];
      next_st.tx_shift = st.tx_shift >> 1;
      next_st.tx_cnt = st.tx_cnt - SCL_CNT_ONE;
    end

    // Detection starts only while the line is already idle.
    case (st.det)
      DET_IDLE: begin
        if (detect_req_i && pcie_mode_i && st.tx_idle) begin
          next_st.det = DET_PULSE;
          next_st.det_cnt = SCL_DET_CNT_W'(SCL_DET_PULSE_CYC);
          next_st.seen = 1'b0;
          next_st.status.detect_done = 1'b0;
        end
      end
      DET_PULSE: begin
        next_st.tx_pulse = 1'b1;
        next_st.det_cnt = st.det_cnt - 1'b1;
        if (st.det_cnt == SCL_DET_CNT_W'(1)) begin
          next_st.det = DET_WAIT;
          next_st.det_cnt = SCL_DET_CNT_W'(SCL_DET_WAIT_CYC);
        end
      end
      DET_WAIT: begin
        // A slow reflection means a load is present on the lane.
        next_st.seen = st.seen | st.sync_refl[1];
        next_st.det_cnt = st.det_cnt - 1'b1;
        if (st.det_cnt == SCL_DET_CNT_W'(1)) begin
          next_st.det = DET_IDLE;
          next_st.status.rx_present = st.seen | st.sync_refl[1];
          next_st.status.detect_done = 1'b1;
        end
      end
      default: next_st.det = DET_IDLE;
    endcase

    // Receive path, no boundary search.
    next_st.rx_word_vld = 1'b0;
    if (st.rx_pd) begin
      next_st.rx_cnt = SCL_CNT_ZERO;
    end else begin
      next_st.rx_shift = {st.sync_rx[1], st.rx_shift[SCL_MAX_W-1:1]};
      next_st.rx_cnt = st.rx_cnt + SCL_CNT_ONE;
      if (st.rx_cnt + SCL_CNT_ONE == wlen) begin
        next_st.rx_word = next_st.rx_shift >> (SCL_MAX_W - wlen);
        next_st.rx_word_vld = 1'b1;
        next_st.rx_cnt = SCL_CNT_ZERO;
      end
    end

    // Lock mode selection; unconnected overrides read low.
    next_st.rx_pd = !rx_used_i;
    if (!rx_used_i) begin
      next_st.lock = SCL_LOCK_OFF;
    end else if (lock_to_data_i) begin
      next_st.lock = SCL_LOCK_DATA;
    end else if (lock_to_ref_i) begin
      next_st.lock = SCL_LOCK_REF;
    end else if (st.lock != SCL_LOCK_DATA) begin
      // Leave reference lock only inside the PPM window.
      next_st.lock = (st.sync_lock[1] && ppm_ok) ? SCL_LOCK_DATA
                                                : SCL_LOCK_REF;
    end else if (!st.sync_lock[1]) begin
      next_st.lock = SCL_LOCK_REF;
    end
    next_st.status.data_locked = next_st.lock == SCL_LOCK_DATA;
    next_st.status.pll_locked = st.sync_lock[1] && rx_used_i;

    next_st.mult = mult_val(mult_sel_i);
    next_st.preemph = preemph_dyn_en_i ? preemph_dyn_i
                                       : PREEMPH_STATIC;
    // Power down only once the adaption has settled.
    next_st.eq_pd = eq_adapt_pd_i && st.sync_settle[1];
    next_st.eq_gain = eq_gain_i;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st <= '0;
      st.det <= DET_IDLE;
      st.lock <= SCL_LOCK_OFF;
      st.rx_pd <= 1'b1;
      st.eq_gain <= SCL_EQ_RESET;
      st.mult <= mult_val(SCL_MULT_RESET);
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Receive FIFO; a full FIFO drops words since the line cannot stall.
  // ==========================================================================
  scl_fifo #(
    .WIDTH(SCL_MAX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(st.rx_word_vld),
    .in_ready_o(),
    .in_data_i(st.rx_word),
    .out_valid_o(fifo_valid),
    // Pop exactly when the output stage loads, so no word shows twice.
    .out_ready_i(!rx_valid_o || rx_ready_i),
    .out_data_o(fifo_data)
  );

  // Registered output stage so the top outputs come from flip-flops.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_valid_o <= 1'b0;
      rx_word_o <= SCL_WORD_ZERO;
      tx_ready_o <= 1'b0;
    end else begin
      if (!rx_valid_o || rx_ready_i) begin
        rx_valid_o <= fifo_valid;
        rx_word_o <= fifo_data;
      end
      tx_ready_o <= next_st.tx_cnt == SCL_CNT_ZERO ||
                    next_st.tx_cnt == SCL_CNT_ONE;
    end
  end

  assign tx_bit_o = st.tx_bit;
  assign tx_idle_o = st.tx_idle;
  assign tx_det_pulse_o = st.tx_pulse;
  assign status_o = st.status;
  assign lock_mode_o = st.lock;
  assign rx_pd_o = st.rx_pd;
  assign eq_pd_o = st.eq_pd;
  assign eq_gain_o = st.eq_gain;
  assign mult_o = st.mult;
  assign preemph_o = st.preemph;

endmodule
`default_nettype wire

// file: scl_lane_properties.sv
/* Port assertions for the transceiver lane.
   Assumes a bind onto scl_lane; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module scl_lane_properties
  import scl_pkg::*;
(
  // One-bit ports
  input wire logic clk_i, srst_i, rx_used_i, lock_to_ref_i,
  input wire logic lock_to_data_i, pcie_mode_i, force_idle_i,
  input wire logic tx_valid_i, tx_ready_o, tx_idle_o, tx_det_pulse_o,
  input wire logic rx_pd_o,
  // Buses
  input wire logic [4:0] ppm_limit_i, ppm_offset_i, mult_o,
  input wire logic [2:0] mult_sel_i, lock_mode_o,
  input wire logic [3:0] status_o
);
  // ======================================
  // Helpers and assertions
  localparam logic [39:0] MULT_TAB = 40'hCD_20A4_1481;
  logic [7:0] run;
  logic auto_sel;
  assign auto_sel = rx_used_i && !lock_to_ref_i && !lock_to_data_i;
  always_ff @(posedge clk_i) begin
    if (srst_i || !tx_det_pulse_o) run <= 8'h00;
    else run <= run + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_lock_data: assert property (
    rx_used_i && lock_to_data_i |=> lock_mode_o == SCL_LOCK_DATA)
    else $error("data override not obeyed");
  a_lock_ref: assert property (
    rx_used_i && lock_to_ref_i && !lock_to_data_i
    |=> lock_mode_o == SCL_LOCK_REF) else $error("ref override lost");
  a_unused_off: assert property (
    !rx_used_i |=> lock_mode_o == SCL_LOCK_OFF && rx_pd_o)
    else $error("unused channel not powered down");
  a_auto_gate: assert property (
    auto_sel && ppm_offset_i > ppm_limit_i && lock_mode_o != SCL_LOCK_DATA
    |=> lock_mode_o == SCL_LOCK_REF)
    else $error("data lock taken outside ppm limit");
  a_idle_follow: assert property (
    !$past(srst_i) |-> tx_idle_o == $past(pcie_mode_i && force_idle_i))
    else $error("electrical idle wrong");
  a_det_start: assert property (
    !$past(srst_i) && $rose(tx_det_pulse_o)
    |-> $past(tx_idle_o && pcie_mode_i)) else $error("pulse while active");
  a_det_len: assert property (
    !$past(srst_i) && $fell(tx_det_pulse_o) |-> run == SCL_DET_PULSE_CYC)
    else $error("detect pulse length wrong");
  a_det_done: assert property (
    !$past(srst_i) && $fell(tx_det_pulse_o) |-> ##[15:26] status_o[0])
    else $error("detect result late");
  a_tx_gap: assert property (
    tx_valid_i && tx_ready_o |=> !(tx_valid_i && tx_ready_o) [*6])
    else $error("word taken too early");
  a_mult_map: assert property (
    !$past(srst_i) |-> mult_o == MULT_TAB[5*$past(mult_sel_i) +: 5])
    else $error("multiplier wrong");
  c_detect: cover property ($rose(tx_det_pulse_o));
  c_data_lock: cover property (lock_mode_o == SCL_LOCK_DATA);
  c_tx_take: cover property (tx_valid_i && tx_ready_o);
endmodule
`default_nettype wire

// file: scl_far_end.sv
/* Far-end serial partner: echoes detection pulses and drives the line.
   Assumes the bench chooses presence and the line pattern. */
`timescale 1ns/1ps
`default_nettype none
module scl_far_end (
  // Clock
  input wire logic clk_i,
  // Lane side
  input wire logic pulse_i,
  output logic reflect_o,
  output logic rx_o,
  // Bench controls
  input wire logic present_i,
  input wire logic [1:0] pat_i
);
  // ======================================
  // Line behaviour
  logic [7:0] echo;
  always_ff @(posedge clk_i) begin
    // The echo outlasts the pulse, as a real reflection arrives late.
    echo <= {echo[6:0], pulse_i};
    reflect_o <= present_i && (echo != 8'h00);
    // Toggling stands for a released line, so no stale level is seen.
    rx_o <= pat_i[1] ? !rx_o : pat_i[0];
  end
endmodule
`default_nettype wire

// file: scl_lane_tb.sv
/* Self-checking bench for scl_lane with the far-end model.
   Assumes package, FIFO, lane, far end and checker compile first. */
`timescale 1ns/1ps
`default_nettype none
module scl_lane_tb;
  import scl_pkg::*;
  // ======================================
  // Stimulus, wiring and helpers
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] width_sel_i = 2'h0, pat = 2'h0;
  logic [2:0] mult_sel_i = 3'h0, lock_mode_o;
  logic [4:0] ppm_limit_i = 5'h05, ppm_offset_i = 5'h00, mult_o;
  logic [3:0] eq_gain_i = 4'h0, preemph_dyn_i = 4'h0;
  logic [3:0] status_o, eq_gain_o, preemph_o;
  logic pcie_mode_i = 1'b0, rx_used_i = 1'b0, eq_adapt_pd_i = 1'b0;
  logic preemph_dyn_en_i = 1'b0, lock_to_ref_i = 1'b0;
  logic lock_to_data_i = 1'b0, pll_lock_raw_i = 1'b0;
  logic eq_settled_i = 1'b0, tx_valid_i = 1'b0, force_idle_i = 1'b0;
  logic detect_req_i = 1'b0, rx_ready_i = 1'b0, present = 1'b0;
  logic [19:0] tx_word_i = 20'h0_0000, rx_word_o;
  logic tx_reflect_i, rx_bit_i, tx_ready_o, tx_bit_o, tx_idle_o, rx_pd_o;
  logic tx_det_pulse_o, rx_valid_o, eq_pd_o;
  int n_fail = 0;
  int total_checks = 0;
  int mtab [8] = '{1, 4, 5, 8, 10, 16, 20, 25};
  always #50 clk_i = ~clk_i;
  scl_lane #(.FIFO_DEPTH(16), .PREEMPH_STATIC(4'h5)) i_dut (
    .clk_i, .srst_i, .width_sel_i, .pcie_mode_i, .rx_used_i, .mult_sel_i,
    .ppm_limit_i, .eq_gain_i, .eq_adapt_pd_i, .preemph_dyn_en_i,
    .preemph_dyn_i, .lock_to_ref_i, .lock_to_data_i, .pll_lock_raw_i,
    .ppm_offset_i, .eq_settled_i, .tx_word_i, .tx_valid_i, .tx_ready_o,
    .force_idle_i, .detect_req_i, .tx_bit_o, .tx_idle_o, .tx_det_pulse_o,
    .tx_reflect_i, .rx_bit_i, .rx_word_o, .rx_valid_o, .rx_ready_i,
    .status_o, .lock_mode_o, .rx_pd_o, .eq_pd_o, .eq_gain_o, .mult_o,
    .preemph_o);
  scl_far_end i_far (.clk_i, .pulse_i(tx_det_pulse_o), .present_i(present),
    .pat_i(pat), .reflect_o(tx_reflect_i), .rx_o(rx_bit_i));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic int wbits(input logic [1:0] s);
    return s == 2'h0 ? 8 : s == 2'h1 ? 10 : s == 2'h2 ? 16 : 20;
  endfunction
  function automatic logic [19:0] wmask(input logic [1:0] s);
    return (20'h0_0001 << wbits(s)) - 20'h0_0001;
  endfunction
  task automatic send(input logic [19:0] w);
    logic [19:0] got;
    int i;
    got = 20'h0_0000;
    @(posedge clk_i);
    tx_word_i <= w;
    tx_valid_i <= 1'b1;
    i = 0;
    do @(negedge clk_i); while (tx_ready_o !== 1'b1 && ++i < 40);
    @(posedge clk_i);
    tx_valid_i <= 1'b0;
    for (i = 0; i < wbits(width_sel_i); i++) begin
      @(negedge clk_i);
      got[i] = tx_bit_o;
    end
    chk(got, w & wmask(width_sel_i));
  endtask
  task automatic lk(input logic [4:0] v, input logic [2:0] e);
    @(posedge clk_i);
    {rx_used_i, lock_to_data_i, lock_to_ref_i, pll_lock_raw_i} <= v[4:1];
    ppm_offset_i <= v[0] ? 5'h06 : 5'h05;
    repeat (6) @(negedge clk_i);
    chk(20'(lock_mode_o), 20'(e));
    chk(20'(status_o[3:2]), 20'({v[1], e == SCL_LOCK_DATA}));
    chk(20'(rx_pd_o), 20'(!v[4]));
  endtask
  task automatic det(input logic [2:0] v);
    int i;
    @(posedge clk_i);
    {present, force_idle_i, pcie_mode_i} <= v;
    repeat (3) @(negedge clk_i);
    chk(20'(tx_idle_o), 20'(v[1] & v[0]));
    @(posedge clk_i);
    detect_req_i <= 1'b1;
    @(posedge clk_i);
    detect_req_i <= 1'b0;
    i = 0;
    do @(negedge clk_i); while (tx_det_pulse_o !== 1'b1 && ++i < 20);
    do @(negedge clk_i); while (status_o[0] !== 1'b1 && ++i < 80);
    chk(20'(status_o[1:0]), 20'(v[1] & v[0] ? {v[2], 1'b1} : 2'h0));
  endtask
  initial begin
    int k, n;
    void'($urandom(32'h44c3_2ee0));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(20'(lock_mode_o), 20'(SCL_LOCK_OFF));
    chk(20'(mult_o), 20'h0_0001);
    @(posedge clk_i);
    srst_i <= 1'b0;
    pat <= 2'h2;
    for (k = 0; k < 4; k++) begin
      @(posedge clk_i);
      width_sel_i <= 2'(k);
      send(20'hF_FFFF);
      send(20'h0_0001);
      repeat (3) send(20'($urandom));
    end
    lk(5'h10, SCL_LOCK_REF);
    lk(5'h13, SCL_LOCK_REF);
    lk(5'h12, SCL_LOCK_DATA);
    lk(5'h19, SCL_LOCK_DATA);
    lk(5'h1E, SCL_LOCK_DATA);
    lk(5'h16, SCL_LOCK_REF);
    lk(5'h00, SCL_LOCK_OFF);
    @(posedge clk_i);
    {rx_used_i, rx_ready_i, pat} <= 4'hD;
    for (k = 0; k < 4; k++) begin
      @(posedge clk_i);
      width_sel_i <= 2'(k);
      repeat (80) @(negedge clk_i);
      n = 0;
      do @(negedge clk_i); while (rx_valid_o !== 1'b1 && ++n < 60);
      chk(rx_word_o, wmask(2'(k)));
    end
    // A stall long enough to overfill the buffer; extra words are dropped.
    @(posedge clk_i);
    {width_sel_i, rx_ready_i} <= 3'h0;
    repeat (400) @(negedge clk_i);
    @(posedge clk_i);
    rx_ready_i <= 1'b1;
    n = 0;
    do @(negedge clk_i); while (rx_valid_o === 1'b1 && ++n < 40);
    chk(20'(n >= 16 && n <= 21), 20'h0_0001);
    det(3'h6);
    det(3'h5);
    det(3'h7);
    det(3'h3);
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      mult_sel_i <= 3'(k);
      eq_gain_i <= 4'($urandom);
      preemph_dyn_i <= 4'($urandom);
      {preemph_dyn_en_i, eq_adapt_pd_i, eq_settled_i} <= 3'($urandom);
      repeat (4) @(negedge clk_i);
      chk(20'(mult_o), 20'(mtab[mult_sel_i]));
      chk(20'(eq_gain_o), 20'(eq_gain_i));
      chk(20'(preemph_o), 20'(preemph_dyn_en_i ? preemph_dyn_i : 4'h5));
      chk(20'(eq_pd_o), 20'(eq_adapt_pd_i & eq_settled_i));
    end
    wrap_up();
  end
  initial begin
    #3_000_000;
    n_fail++;
    wrap_up();
  end
endmodule
bind scl_lane scl_lane_properties i_prop (
  .clk_i, .srst_i, .rx_used_i, .lock_to_ref_i, .lock_to_data_i,
  .pcie_mode_i, .force_idle_i, .tx_valid_i, .tx_ready_o, .tx_idle_o,
  .tx_det_pulse_o, .rx_pd_o, .ppm_limit_i, .ppm_offset_i, .mult_o,
  .mult_sel_i, .lock_mode_o, .status_o);
`default_nettype wire
